// >>> common/prog_entry_pkg.sv
package prog_entry_pkg;
	localparam int              CMD_BITS      = 6;
	localparam int              WORD_BITS     = 14;
	localparam int              EVT_BITS      = WORD_BITS + 1;
	localparam int              FIFO_DEPTH    = 32;
	localparam int              PIN_COUNT     = 3;
	localparam logic [CMD_BITS-1:0] CMD_LOAD  = 6'h02;
	localparam logic [CMD_BITS-1:0] CMD_READ  = 6'h04;
	localparam logic [3:0]      LAST_CMD_BIT  = 4'h5;
	localparam logic [3:0]      LAST_WORD_BIT = 4'hD;
	localparam logic [1:0]      PIN_CLEAR     = 2'h2;
	localparam logic [1:0]      PIN_CLOCK     = 2'h1;
	localparam logic [1:0]      PIN_DATA      = 2'h0;
	localparam logic            TAG_COMMAND   = 1'h1;
	localparam logic            TAG_LOAD      = 1'h0;
	localparam logic [WORD_BITS-1:0] STALE_WORD = 14'h3FFF;
	typedef enum logic [1:0] {LINK_CMD, LINK_LOAD, LINK_READ} link_state_t;
endpackage

// >>> common/stream_if.sv
`timescale 1ns/100ps
interface stream_if #(parameter int WIDTH = 8);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// >>> hdl/prog_entry_port.sv
`timescale 1ns/100ps
module prog_entry_port (
	input  wire logic                            ref_clk,
	input  wire logic                            sys_rst,
	input  wire logic                            progClkPin,
	input  wire logic                            progDataPinIn,
	output logic                                 progDataPinOut,
	output logic                                 progDataPinOe,
	input  wire logic                            clearHighLevel,
	input  wire logic [prog_entry_pkg::WORD_BITS-1:0] memRdData,
	output logic                                 progMode,
	output logic                                 evtValid,
	input  wire logic                            evtReady,
	output logic                                 evtIsCmd,
	output logic [prog_entry_pkg::WORD_BITS-1:0] evtWord,
	output logic                                 evtDropped
);
	import prog_entry_pkg::*;

	logic [PIN_COUNT-1:0] pinRaw;
	logic [PIN_COUNT-1:0] pinMeta_ff;
	logic [PIN_COUNT-1:0] pinSync_ff;
	logic                 clearPrev_ff;
	logic                 progMode_ff;
	logic                 linkRst;
	logic                 entryCond;

	// Pin levels into the reference domain
	assign pinRaw = {clearHighLevel, progClkPin, progDataPinIn};

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pinMeta_ff <= '0;
			pinSync_ff <= '0;
		end else begin
			pinMeta_ff <= pinRaw;
			pinSync_ff <= pinMeta_ff;
		end
	end

	// Clear level rising while clock and data are held low
	assign entryCond = pinSync_ff[PIN_CLEAR] & ~clearPrev_ff
		& ~pinSync_ff[PIN_CLOCK] & ~pinSync_ff[PIN_DATA];

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			clearPrev_ff <= 1'b0;
		end else begin
			clearPrev_ff <= pinSync_ff[PIN_CLEAR];
		end
	end

	// Mode flag: entered on the qualified rise, left when clear drops
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			progMode_ff <= 1'b0;
		end else if (!pinSync_ff[PIN_CLEAR]) begin
			progMode_ff <= 1'b0;
		end else if (entryCond) begin
			progMode_ff <= 1'b1;
		end
	end

	// Mode exit resets the link side; release at entry comes while clock is held low
	assign linkRst = ~progMode_ff;

	link_state_t          state_ff;
	logic [3:0]           bitCnt_ff;
	logic [WORD_BITS-1:0] shift_ff;
	logic [WORD_BITS-1:0] nxtShift;
	logic [CMD_BITS-1:0]  rxCmd;
	logic [WORD_BITS-1:0] outShift_ff;
	logic                 shiftBit1;
	logic                 dataOut_ff;
	logic                 dataOe_ff;
	logic                 cmdDone;
	logic                 wordDone;
	logic                 sendEvt;
	logic                 evtBusy;
	logic                 evtReq_ff;
	logic                 evtTag_ff;
	logic [WORD_BITS-1:0] evtWord_ff;
	logic                 ackMeta_ff;
	logic                 ackSync_ff;
	logic                 dropped_ff;
	logic                 freezeReq_ff;
	logic                 frzMeta_ff;
	logic                 frzSync_ff;
	logic                 evtMeta_ff;
	logic                 evtSync_ff;
	logic                 evtSeen_ff;
	logic                 newEvt;
	logic                 frzReqMeta_ff;
	logic                 frzReqSync_ff;
	logic                 frzAck_ff;
	logic [WORD_BITS-1:0] readHold_ff;

	// Data bits enter at the top, least significant bit first
	always_comb begin
		nxtShift = {progDataPinIn, shift_ff[WORD_BITS-1:1]};
		rxCmd    = nxtShift[WORD_BITS-1 -: CMD_BITS];
	end

	assign cmdDone   = (state_ff == LINK_CMD) && (bitCnt_ff == LAST_CMD_BIT);
	assign wordDone  = (state_ff != LINK_CMD) && (bitCnt_ff == LAST_WORD_BIT);
	assign sendEvt   = cmdDone || (wordDone && state_ff == LINK_LOAD);
	assign evtBusy   = evtReq_ff != ackSync_ff;
	assign shiftBit1 = outShift_ff[1];

	// Serial input shifter on the programming clock
	always_ff @(posedge progClkPin or posedge linkRst) begin
		if (linkRst) begin
			shift_ff <= '0;
		end else begin
			shift_ff <= nxtShift;
		end
	end

	// Bit counter for the current field
	always_ff @(posedge progClkPin or posedge linkRst) begin
		if (linkRst) begin
			bitCnt_ff <= '0;
		end else if (cmdDone || wordDone) begin
			bitCnt_ff <= '0;
		end else begin
			bitCnt_ff <= bitCnt_ff + 1'b1;
		end
	end

	// Field sequencer: command first, then a word for load or read
	always_ff @(posedge progClkPin or posedge linkRst) begin
		if (linkRst) begin
			state_ff <= LINK_CMD;
		end else begin
			case (state_ff)
				LINK_CMD: begin
					if (cmdDone && rxCmd == CMD_LOAD) begin
						state_ff <= LINK_LOAD;
					end else if (cmdDone && rxCmd == CMD_READ) begin
						state_ff <= LINK_READ;
					end
				end
				LINK_LOAD, LINK_READ: begin
					if (wordDone) begin
						state_ff <= LINK_CMD;
					end
				end
				default: begin
					state_ff <= LINK_CMD;
				end
			endcase
		end
	end

	// Read word driven out, a new bit after every rising edge
	always_ff @(posedge progClkPin or posedge linkRst) begin
		if (linkRst) begin
			outShift_ff <= '0;
			dataOut_ff  <= 1'b0;
			dataOe_ff   <= 1'b0;
		end else if (cmdDone && rxCmd == CMD_READ) begin
			outShift_ff <= frzSync_ff ? readHold_ff : STALE_WORD;
			dataOut_ff  <= frzSync_ff ? readHold_ff[0] : 1'b1;
			dataOe_ff   <= 1'b1;
		end else if (state_ff == LINK_READ) begin
			outShift_ff <= outShift_ff >> 1;
			dataOut_ff  <= wordDone ? 1'b0 : outShift_ff[1];
			dataOe_ff   <= ~wordDone;
		end
	end

	// Freeze request keeps the read word still while a command arrives
	always_ff @(posedge progClkPin or posedge linkRst) begin
		if (linkRst) begin
			freezeReq_ff <= 1'b0;
		end else if (state_ff == LINK_CMD && bitCnt_ff == '0) begin
			freezeReq_ff <= 1'b1;
		end else if ((cmdDone && rxCmd != CMD_READ) || (wordDone && state_ff == LINK_READ)) begin
			freezeReq_ff <= 1'b0;
		end
	end

	// Acknowledges back from the reference domain
	always_ff @(posedge progClkPin or posedge linkRst) begin
		if (linkRst) begin
			ackMeta_ff <= 1'b0;
			ackSync_ff <= 1'b0;
			frzMeta_ff <= 1'b0;
			frzSync_ff <= 1'b0;
		end else begin
			ackMeta_ff <= evtSeen_ff;
			ackSync_ff <= ackMeta_ff;
			frzMeta_ff <= frzAck_ff;
			frzSync_ff <= frzMeta_ff;
		end
	end

	// Completed command fields and load words offered by toggle handshake; read words are not
	always_ff @(posedge progClkPin or posedge linkRst) begin
		if (linkRst) begin
			evtReq_ff  <= 1'b0;
			evtTag_ff  <= TAG_COMMAND;
			evtWord_ff <= '0;
		end else if (sendEvt && !evtBusy) begin
			evtReq_ff  <= ~evtReq_ff;
			evtTag_ff  <= cmdDone ? TAG_COMMAND : TAG_LOAD;
			evtWord_ff <= cmdDone ? {{(WORD_BITS-CMD_BITS){1'b0}}, rxCmd} : nxtShift;
		end
	end

	// Sticky loss flag when the previous field is still unaccepted
	always_ff @(posedge progClkPin or posedge linkRst) begin
		if (linkRst) begin
			dropped_ff <= 1'b0;
		end else if (sendEvt && evtBusy) begin
			dropped_ff <= 1'b1;
		end
	end


	stream_if #(.WIDTH(EVT_BITS)) fifoIn ();
	stream_if #(.WIDTH(EVT_BITS)) fifoOut ();

	// Handshake levels into the reference domain
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			evtMeta_ff    <= 1'b0;
			evtSync_ff    <= 1'b0;
			frzReqMeta_ff <= 1'b0;
			frzReqSync_ff <= 1'b0;
		end else begin
			evtMeta_ff    <= evtReq_ff;
			evtSync_ff    <= evtMeta_ff;
			frzReqMeta_ff <= freezeReq_ff;
			frzReqSync_ff <= frzReqMeta_ff;
		end
	end

	// Offered field is stable until acknowledged, so it is read directly
	assign newEvt        = evtSync_ff != evtSeen_ff;
	assign fifoIn.valid  = newEvt;
	assign fifoIn.data   = {evtTag_ff, evtWord_ff};
	assign fifoOut.ready = evtReady;

	// Acknowledge only once the buffer takes the field
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			evtSeen_ff <= 1'b0;
		end else if (newEvt && fifoIn.ready) begin
			evtSeen_ff <= evtSync_ff;
		end
	end

	// Read word sampled from memory until frozen
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			readHold_ff <= '0;
			frzAck_ff   <= 1'b0;
		end else begin
			frzAck_ff <= frzReqSync_ff;
			if (!frzReqSync_ff && !frzAck_ff) begin
				readHold_ff <= memRdData;
			end
		end
	end

	stream_fifo #(
		.WIDTH (EVT_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk (ref_clk),
		.rst (sys_rst),
		.wr  (fifoIn),
		.rd  (fifoOut)
	);

	// Outputs, each from a flip-flop
	assign progMode       = progMode_ff;
	assign progDataPinOut = dataOut_ff;
	assign progDataPinOe  = dataOe_ff;
	assign evtValid       = fifoOut.valid;
	assign evtIsCmd       = fifoOut.data[EVT_BITS-1];
	assign evtWord        = fifoOut.data[WORD_BITS-1:0];
	assign evtDropped     = dropped_ff;

	// Checks on entry, framing and transfer
	sequence loadOpen;
		state_ff == LINK_LOAD && bitCnt_ff == '0;
	endsequence

	sequence loadClose;
		state_ff == LINK_LOAD && bitCnt_ff == LAST_WORD_BIT ##1 state_ff == LINK_CMD;
	endsequence

	modeEntry_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		entryCond |=> progMode_ff ##1 (progMode_ff || !pinSync_ff[PIN_CLEAR]))
		else $error("mode not entered on qualified clear rise");

	modeExit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!pinSync_ff[PIN_CLEAR] |=> !progMode_ff)
		else $error("mode kept after clear level dropped");

	cmdLength_a: assert property (@(posedge progClkPin) disable iff (linkRst)
		(state_ff == LINK_CMD && bitCnt_ff == '0)
		|-> ##5 (state_ff == LINK_CMD && bitCnt_ff == LAST_CMD_BIT))
		else $error("command field not six bits");

	loadLength_a: assert property (@(posedge progClkPin) disable iff (linkRst)
		loadOpen |-> ##13 loadClose)
		else $error("load word not fourteen bits");

	loadEvent_a: assert property (@(posedge progClkPin) disable iff (linkRst)
		(wordDone && state_ff == LINK_LOAD && !evtBusy)
		|=> evtWord_ff == $past(nxtShift) && evtTag_ff == TAG_LOAD)
		else $error("loaded word not offered");

	readDrive_a: assert property (@(posedge progClkPin) disable iff (linkRst)
		$rose(dataOe_ff) |-> ##13 dataOe_ff ##1 !dataOe_ff)
		else $error("read drive not fourteen clocks");

	readOrder_a: assert property (@(posedge progClkPin) disable iff (linkRst)
		(state_ff == LINK_READ && !wordDone) |=> dataOut_ff == $past(shiftBit1))
		else $error("read bits not least first");

	holdStable_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(frzAck_ff && $past(frzAck_ff)) |-> $stable(readHold_ff))
		else $error("read word moved while frozen");
endmodule

// >>> hdl/stream_fifo.sv
`timescale 1ns/100ps
module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic clk,
	input  wire logic rst,
	stream_if.snk     wr,
	stream_if.src     rd
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_ff;
	logic [AW-1:0]    rdPtr_ff;
	logic [AW:0]      count_ff;
	logic [WIDTH-1:0] rdData_ff;
	logic             rdValid_ff;
	logic             push;
	logic             pop;

	// Full and empty follow the occupancy count; depth is a power of two
	assign wr.ready = (count_ff != (AW+1)'(DEPTH));
	assign push     = wr.valid & wr.ready;
	assign pop      = (count_ff != '0) & (~rdValid_ff | rd.ready);
	assign rd.valid = rdValid_ff;
	assign rd.data  = rdData_ff;

	// Storage array, no reset needed
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_ff] <= wr.data;
		end
	end

	// Pointers and count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push) begin
				wrPtr_ff <= wrPtr_ff + 1'b1;
			end
			if (pop) begin
				rdPtr_ff <= rdPtr_ff + 1'b1;
			end
			count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Registered read side; the drain can stall it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdValid_ff <= 1'b0;
			rdData_ff  <= '0;
		end else if (pop) begin
			rdValid_ff <= 1'b1;
			rdData_ff  <= mem[rdPtr_ff];
		end else if (rd.ready) begin
			rdValid_ff <= 1'b0;
		end
	end
endmodule

// >>> testbench/prog_programmer.sv
`timescale 1ns/100ps
module prog_programmer
	import prog_entry_pkg::*;
(
	output logic      clkPin,
	output logic      dataDrv,
	output logic      dataEn,
	output logic      clearHigh,
	input  wire logic dataLine
);
	// Idle: clock still and low, data driven low
	initial begin
		clkPin = 1'h0;
		dataDrv = 1'h0;
		dataEn = 1'h1;
		clearHigh = 1'h0;
	end
	// Clock and data low while clear goes high, clock quiet after
	task automatic enter_mode();
		dataDrv = 1'h0;
		dataEn = 1'h1;
		#10 clearHigh = 1'h1;
		#100;
	endtask
	task automatic leave_mode();
		clearHigh = 1'h0;
		#100;
	endtask
	// Command then word bits, LSB first, rising edge; line taken at each fall
	task automatic frame(input logic [CMD_BITS-1:0] cmd, input logic [WORD_BITS-1:0] word,
		input int nWord, input logic rel, output logic [19:0] seen);
		seen = '0;
		for (int i = 0; i < CMD_BITS + nWord; i++) begin
			if (i < CMD_BITS) begin
				dataDrv = cmd[i];
			end else begin
				dataDrv = word[i-CMD_BITS];
			end
			#15 clkPin = 1'h1;
			#15 seen[i] = dataLine;
			// Let go of data at the fall after the last read command bit
			if (rel && i == CMD_BITS - 1) begin
				dataEn = 1'h0;
			end
			clkPin = 1'h0;
		end
		dataEn = 1'h1;
		dataDrv = 1'h0;
	endtask
endmodule

// >>> testbench/serial_program_entry_port_tb_top.sv
`timescale 1ns/100ps
module serial_program_entry_port_tb_top;
	import prog_entry_pkg::*;
	logic                 refClk;
	logic                 sysRst;
	logic                 progClk;
	logic                 hostDrv;
	logic                 hostEn;
	logic                 clearHigh;
	logic                 dataLine;
	logic                 devOut;
	logic                 devOe;
	logic [WORD_BITS-1:0] memWord;
	logic                 progMode;
	logic                 evtValid;
	logic                 evtReady;
	logic                 evtIsCmd;
	logic [WORD_BITS-1:0] evtWord;
	logic                 evtDropped;
	logic [19:0]          seen;
	int                   mismatches;
	int                   totalChecks;

	// Wire level: device first, then programmer, else stale inverse
	assign dataLine = devOe ? devOut : (hostEn ? hostDrv : ~devOut);

	initial begin
		refClk = 1'h0;
		forever #5 refClk = ~refClk;
	end

	prog_entry_port i_prog_entry_port (
		.ref_clk        (refClk),
		.sys_rst        (sysRst),
		.progClkPin     (progClk),
		.progDataPinIn  (dataLine),
		.progDataPinOut (devOut),
		.progDataPinOe  (devOe),
		.clearHighLevel (clearHigh),
		.memRdData      (memWord),
		.progMode       (progMode),
		.evtValid       (evtValid),
		.evtReady       (evtReady),
		.evtIsCmd       (evtIsCmd),
		.evtWord        (evtWord),
		.evtDropped     (evtDropped)
	);

	prog_programmer i_prog_programmer (
		.clkPin    (progClk),
		.dataDrv   (hostDrv),
		.dataEn    (hostEn),
		.clearHigh (clearHigh),
		.dataLine  (dataLine)
	);

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		totalChecks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask

	task automatic endOfTest();
		$display("Checks %0d, mismatches %0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Wait for an event, compare tag and payload, accept it
	task automatic take_evt(input logic isCmd, input logic [WORD_BITS-1:0] word);
		int n;
		n = 0;
		@(negedge refClk);
		while (evtValid !== 1'h1 && n < 200) begin
			@(negedge refClk);
			n++;
		end
		check(16'({evtValid, evtIsCmd, evtWord}), 16'({1'h1, isCmd, word}));
		evtReady = 1'h1;
		@(negedge refClk);
		evtReady = 1'h0;
	endtask

	task automatic scen_load();
		i_prog_programmer.frame(CMD_LOAD, 14'h2A5C, 14, 1'h0, seen);
		take_evt(1'h1, 14'(CMD_LOAD));
		take_evt(1'h0, 14'h2A5C);
	endtask

	task automatic scen_read(input logic [WORD_BITS-1:0] word);
		@(negedge refClk);
		memWord = word;
		repeat (4) @(negedge refClk);
		i_prog_programmer.frame(CMD_READ, 14'h0000, 14, 1'h1, seen);
		check(16'(seen[18:5]), 16'(word));
		check(16'(devOe), 16'h0);
		take_evt(1'h1, 14'(CMD_READ));
	endtask

	// Unknown command has no data phase; a load follows at once
	task automatic scen_unknown();
		i_prog_programmer.frame(6'h3F, 14'h0000, 0, 1'h0, seen);
		i_prog_programmer.frame(CMD_LOAD, 14'h0001, 14, 1'h0, seen);
		take_evt(1'h1, 14'h003F);
		take_evt(1'h1, 14'(CMD_LOAD));
		take_evt(1'h0, 14'h0001);
	endtask

	// Drain stalled: fields overflow the buffer, then it is emptied
	task automatic scen_full();
		int cnt;
		cnt = 0;
		for (int i = 0; i < 40; i++) begin
			i_prog_programmer.frame(6'h15, 14'h0000, 0, 1'h0, seen);
		end
		repeat (10) @(negedge refClk);
		check(16'(evtDropped), 16'h1);
		for (int i = 0; i < 120; i++) begin
			@(negedge refClk);
			if (evtValid === 1'h1) begin
				cnt++;
				check(16'({evtIsCmd, evtWord}), 16'h4015);
				evtReady = 1'h1;
				@(negedge refClk);
				evtReady = 1'h0;
			end
		end
		check(16'(cnt >= FIFO_DEPTH && cnt < 40), 16'h1);
	endtask

	initial begin
		#300000;
		mismatches++;
		endOfTest();
	end

	initial begin
		mismatches = 0;
		totalChecks = 0;
		sysRst = 1'h1;
		evtReady = 1'h0;
		memWord = 14'h0000;
		repeat (16) @(negedge refClk);
		check(16'({progMode, evtValid, devOe}), 16'h0);
		sysRst = 1'h0;
		repeat (4) @(negedge refClk);
		i_prog_programmer.enter_mode();
		check(16'(progMode), 16'h1);
		scen_load();
		scen_read(14'h1B37);
		scen_read(14'h24C8);
		scen_unknown();
		scen_full();
		i_prog_programmer.leave_mode();
		check(16'({progMode, evtDropped, devOe}), 16'h0);
		endOfTest();
	end
endmodule
